// >>> core/csb_pkg.sv
// constants and types of the compare, skip and branch unit
package csb_pkg;

   // widths
   localparam int unsigned instr_w = 16;
   localparam int unsigned pc_w = 16;
   localparam int unsigned data_w = 8;
   localparam int unsigned flag_w = 8;
   localparam int unsigned rf_addr_w = 5;
   localparam int unsigned io_addr_w = 5;
   localparam int unsigned bit_sel_w = 3;
   localparam int unsigned disp_w = 7;
   localparam int unsigned bus_addr_w = 8;
   localparam int unsigned bus_data_w = 32;
   localparam int unsigned count_w = 16;

   // status_flags bit positions
   localparam logic [2:0] flag_carry = 3'h0;
   localparam logic [2:0] flag_zero = 3'h1;
   localparam logic [2:0] flag_neg = 3'h2;
   localparam logic [2:0] flag_ovf = 3'h3;
   localparam logic [2:0] flag_sign = 3'h4;
   localparam logic [2:0] flag_half = 3'h5;
   localparam logic [2:0] flag_tbit = 3'h6;
   localparam logic [2:0] flag_intr = 3'h7;

   // instruction word fields
   localparam int unsigned op_lo = 12;
   localparam int unsigned rd_lo = 5;
   localparam int unsigned rr_lo = 0;
   localparam int unsigned imm_rd_lo = 8;
   localparam int unsigned imm_lo = 0;
   localparam int unsigned skip_reg_lo = 4;
   localparam int unsigned io_lo = 3;
   localparam int unsigned bit_lo = 0;
   localparam int unsigned flag_idx_lo = 0;
   localparam int unsigned bdisp_lo = 3;
   localparam int unsigned cond_lo = 8;
   localparam int unsigned ndisp_lo = 0;
   localparam logic imm_rd_base = 1'h1;

   // instruction kinds
   typedef enum logic [3:0] {
      op_compare_regs = 4'h0,
      op_compare_with_borrow = 4'h1,
      op_compare_immediate = 4'h2,
      op_skip_reg_bit_clear = 4'h3,
      op_skip_reg_bit_set = 4'h4,
      op_skip_io_bit_clear = 4'h5,
      op_skip_io_bit_set = 4'h6,
      op_branch_flag_set = 4'h7,
      op_branch_flag_clear = 4'h8,
      op_branch_named = 4'h9
   } csb_op_type;

   // named branch conditions
   typedef enum logic [3:0] {
      cond_branch_equal = 4'h0,
      cond_branch_not_equal = 4'h1,
      cond_branch_carry_set = 4'h2,
      cond_branch_carry_clear = 4'h3,
      cond_branch_same_higher = 4'h4,
      cond_branch_lower = 4'h5,
      cond_branch_minus = 4'h6,
      cond_branch_plus = 4'h7,
      cond_branch_ge_signed = 4'h8,
      cond_branch_lt_signed = 4'h9,
      cond_branch_half_set = 4'ha,
      cond_branch_half_clear = 4'hb,
      cond_branch_tbit_set = 4'hc,
      cond_branch_tbit_clear = 4'hd,
      cond_branch_ovf_set = 4'he,
      cond_branch_ovf_clear = 4'hf
   } csb_cond_type;

   // execution states
   typedef enum logic [0:0] {
      st_idle = 1'h0,
      st_stall = 1'h1
   } csb_state_type;

   // cycle counts and pc steps
   localparam logic [1:0] cyc_skip_one = 2'h2;
   localparam logic [1:0] cyc_skip_two = 2'h3;
   localparam logic [1:0] cyc_branch = 2'h2;
   localparam logic [1:0] cyc_one = 2'h1;
   localparam logic [pc_w-1:0] pc_skip_one = 16'h0002;
   localparam logic [pc_w-1:0] pc_skip_two = 16'h0003;
   localparam logic [pc_w-1:0] pc_rel_base = 16'h0001;

   // register map
   localparam logic [bus_addr_w-1:0] reg_ctrl = 8'h00;
   localparam logic [bus_addr_w-1:0] reg_state = 8'h04;
   localparam logic [bus_addr_w-1:0] reg_branch_count = 8'h08;
   localparam logic [bus_addr_w-1:0] reg_skip_count = 8'h0c;
   localparam logic [bus_addr_w-1:0] reg_last_target = 8'h10;
   localparam int unsigned ctrl_enable_bit = 0;
   localparam int unsigned state_busy_bit = 0;
   localparam int unsigned state_taken_bit = 1;
   localparam logic ctrl_enable_rst = 1'h1;

endpackage : csb_pkg

// >>> core/csb_cmp_if.sv
// carrier between the unit and its subtractor
`timescale 1ns/1ps
`default_nettype none
interface csb_cmp_if;
   logic [csb_pkg::data_w-1:0] op_a;
   logic [csb_pkg::data_w-1:0] op_b;
   logic borrow_in;
   logic zero;
   logic neg;
   logic ovf;
   logic carry;
   logic half;
   modport unit (output op_a, op_b, borrow_in,
      input zero, neg, ovf, carry, half);
   modport alu (input op_a, op_b, borrow_in,
      output zero, neg, ovf, carry, half);
endinterface : csb_cmp_if
`default_nettype wire

// >>> core/csb_cmp_sub.sv
// subtractor producing compare flags
`timescale 1ns/1ps
`default_nettype none
module csb_cmp_sub (
   csb_cmp_if.alu cmp
);
   logic [csb_pkg::data_w:0] diff;
   logic [4:0] low_diff;
   logic [csb_pkg::data_w-1:0] res;

   // a minus b minus borrow, result dropped
   assign diff = {1'h0, cmp.op_a} - {1'h0, cmp.op_b}
      - {{csb_pkg::data_w{1'h0}}, cmp.borrow_in};
   assign low_diff = {1'h0, cmp.op_a[3:0]} - {1'h0, cmp.op_b[3:0]}
      - {4'h0, cmp.borrow_in};
   assign res = diff[csb_pkg::data_w-1:0];
   assign cmp.carry = diff[csb_pkg::data_w];
   assign cmp.half = low_diff[4];
   assign cmp.zero = (res == 8'h00);
   assign cmp.neg = res[7];
   assign cmp.ovf = (cmp.op_a[7] & ~cmp.op_b[7] & ~res[7])
      | (~cmp.op_a[7] & cmp.op_b[7] & res[7]);
endmodule // csb_cmp_sub
`default_nettype wire

// >>> core/csb_unit.sv
// compare, skip and branch execution unit
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module csb_unit (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // instruction issue
   input wire logic instr_valid,
   input wire logic [csb_pkg::instr_w-1:0] instr_word,
   input wire logic [csb_pkg::pc_w-1:0] instr_pc,
   input wire logic next_two_word,
   output logic instr_ready,
   output logic exec_done,
   // register file read ports
   output logic [csb_pkg::rf_addr_w-1:0] rf_addr_a,
   input wire logic [csb_pkg::data_w-1:0] rf_data_a,
   output logic [csb_pkg::rf_addr_w-1:0] rf_addr_b,
   input wire logic [csb_pkg::data_w-1:0] rf_data_b,
   // i/o bit read path
   output logic [csb_pkg::io_addr_w-1:0] io_addr,
   input wire logic [csb_pkg::data_w-1:0] io_data,
   // status flags
   input wire logic [csb_pkg::flag_w-1:0] flags_in,
   output logic flags_we,
   output logic [csb_pkg::flag_w-1:0] flags_out,
   // program counter
   output logic pc_load,
   output logic [csb_pkg::pc_w-1:0] pc_target,
   // register port
   input wire logic [csb_pkg::bus_addr_w-1:0] reg_addr,
   input wire logic [csb_pkg::bus_data_w-1:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [csb_pkg::bus_data_w-1:0] reg_rdata
);

   // sign extends a word displacement
   function automatic logic [csb_pkg::pc_w-1:0] sext_disp(
      input logic [csb_pkg::disp_w-1:0] k);
      sext_disp = {{(csb_pkg::pc_w-csb_pkg::disp_w){k[csb_pkg::disp_w-1]}},
         k};
   endfunction

   // picks one bit of a byte
   function automatic logic pick_bit(
      input logic [csb_pkg::data_w-1:0] val,
      input logic [csb_pkg::bit_sel_w-1:0] sel);
      pick_bit = val[sel];
   endfunction

   // evaluates a named branch condition
   function automatic logic named_met(
      input csb_pkg::csb_cond_type cond,
      input logic [csb_pkg::flag_w-1:0] f);
      logic sgn;
      sgn = f[csb_pkg::flag_neg] ^ f[csb_pkg::flag_ovf];
      case (cond)
         csb_pkg::cond_branch_equal: named_met = f[csb_pkg::flag_zero];
         csb_pkg::cond_branch_not_equal: named_met = ~f[csb_pkg::flag_zero];
         csb_pkg::cond_branch_carry_set,
         csb_pkg::cond_branch_lower: named_met = f[csb_pkg::flag_carry];
         csb_pkg::cond_branch_carry_clear,
         csb_pkg::cond_branch_same_higher:
            named_met = ~f[csb_pkg::flag_carry];
         csb_pkg::cond_branch_minus: named_met = f[csb_pkg::flag_neg];
         csb_pkg::cond_branch_plus: named_met = ~f[csb_pkg::flag_neg];
         csb_pkg::cond_branch_ge_signed: named_met = ~sgn;
         csb_pkg::cond_branch_lt_signed: named_met = sgn;
         csb_pkg::cond_branch_half_set: named_met = f[csb_pkg::flag_half];
         csb_pkg::cond_branch_half_clear:
            named_met = ~f[csb_pkg::flag_half];
         csb_pkg::cond_branch_tbit_set: named_met = f[csb_pkg::flag_tbit];
         csb_pkg::cond_branch_tbit_clear:
            named_met = ~f[csb_pkg::flag_tbit];
         csb_pkg::cond_branch_ovf_set: named_met = f[csb_pkg::flag_ovf];
         csb_pkg::cond_branch_ovf_clear: named_met = ~f[csb_pkg::flag_ovf];
         default: named_met = 1'h0;
      endcase
   endfunction

   // state
   csb_pkg::csb_state_type state_q;
   csb_pkg::csb_state_type state_d;
   logic [1:0] stall_q;
   logic [1:0] stall_d;
   logic enable_q;
   logic flags_we_q;
   logic [csb_pkg::flag_w-1:0] flags_out_q;
   logic pc_load_q;
   logic [csb_pkg::pc_w-1:0] pc_target_q;
   logic done_q;
   logic last_taken_q;
   logic [csb_pkg::count_w-1:0] branch_count_q;
   logic [csb_pkg::count_w-1:0] skip_count_q;
   logic [csb_pkg::pc_w-1:0] last_target_q;
   logic [csb_pkg::bus_data_w-1:0] rdata_q;

   // field decode
   csb_pkg::csb_op_type op;
   csb_pkg::csb_cond_type cond;
   logic [csb_pkg::rf_addr_w-1:0] fld_rd;
   logic [csb_pkg::rf_addr_w-1:0] fld_rr;
   logic [csb_pkg::rf_addr_w-1:0] fld_imm_rd;
   logic [csb_pkg::rf_addr_w-1:0] fld_skip_reg;
   logic [csb_pkg::data_w-1:0] fld_imm;
   logic [csb_pkg::bit_sel_w-1:0] fld_bit;
   logic [csb_pkg::bit_sel_w-1:0] fld_flag;
   logic [csb_pkg::disp_w-1:0] fld_bdisp;
   logic [csb_pkg::disp_w-1:0] fld_ndisp;

   assign op = csb_pkg::csb_op_type'(instr_word[csb_pkg::op_lo +: 4]);
   assign cond = csb_pkg::csb_cond_type'(instr_word[csb_pkg::cond_lo +: 4]);
   assign fld_rd = instr_word[csb_pkg::rd_lo +: csb_pkg::rf_addr_w];
   assign fld_rr = instr_word[csb_pkg::rr_lo +: csb_pkg::rf_addr_w];
   assign fld_imm_rd = {csb_pkg::imm_rd_base,
      instr_word[csb_pkg::imm_rd_lo +: 4]};
   assign fld_skip_reg = instr_word[csb_pkg::skip_reg_lo +: csb_pkg::rf_addr_w];
   assign fld_imm = instr_word[csb_pkg::imm_lo +: csb_pkg::data_w];
   assign fld_bit = instr_word[csb_pkg::bit_lo +: csb_pkg::bit_sel_w];
   assign fld_flag = instr_word[csb_pkg::flag_idx_lo +: csb_pkg::bit_sel_w];
   assign fld_bdisp = instr_word[csb_pkg::bdisp_lo +: csb_pkg::disp_w];
   assign fld_ndisp = instr_word[csb_pkg::ndisp_lo +: csb_pkg::disp_w];

   // instruction classes
   logic is_cmp_reg;
   logic is_cmp_brw;
   logic is_cmp_imm;
   logic is_cmp;
   logic is_skip_reg;
   logic is_skip_io;
   logic is_skip;
   logic is_bflag;
   logic is_branch;

   assign is_cmp_reg = (op == csb_pkg::op_compare_regs);
   assign is_cmp_brw = (op == csb_pkg::op_compare_with_borrow);
   assign is_cmp_imm = (op == csb_pkg::op_compare_immediate);
   assign is_cmp = is_cmp_reg | is_cmp_brw | is_cmp_imm;
   assign is_skip_reg = (op == csb_pkg::op_skip_reg_bit_clear)
      | (op == csb_pkg::op_skip_reg_bit_set);
   assign is_skip_io = (op == csb_pkg::op_skip_io_bit_clear)
      | (op == csb_pkg::op_skip_io_bit_set);
   assign is_skip = is_skip_reg | is_skip_io;
   assign is_bflag = (op == csb_pkg::op_branch_flag_set)
      | (op == csb_pkg::op_branch_flag_clear);
   assign is_branch = is_bflag | (op == csb_pkg::op_branch_named);

   // read port addressing
   assign rf_addr_a = is_cmp_imm ? fld_imm_rd
      : (is_skip_reg ? fld_skip_reg : fld_rd);
   assign rf_addr_b = fld_rr;
   assign io_addr = instr_word[csb_pkg::io_lo +: csb_pkg::io_addr_w];

   // compare subtractor
   csb_cmp_if cmp_bus ();

   assign cmp_bus.op_a = rf_data_a;
   assign cmp_bus.op_b = is_cmp_imm ? fld_imm : rf_data_b;
   assign cmp_bus.borrow_in = is_cmp_brw & flags_in[csb_pkg::flag_carry];

   csb_cmp_sub u_cmp_sub (
      .cmp (cmp_bus.alu)
   );

   // flags after a compare
   logic [csb_pkg::flag_w-1:0] cmp_flags;

   always_comb begin
      cmp_flags = flags_in;
      cmp_flags[csb_pkg::flag_zero] = cmp_bus.zero;
      cmp_flags[csb_pkg::flag_neg] = cmp_bus.neg;
      cmp_flags[csb_pkg::flag_ovf] = cmp_bus.ovf;
      cmp_flags[csb_pkg::flag_carry] = cmp_bus.carry;
      cmp_flags[csb_pkg::flag_half] = cmp_bus.half;
   end

   // skip decision
   logic reg_bit;
   logic io_bit;
   logic skip_take;

   assign reg_bit = pick_bit(rf_data_a, fld_bit);
   assign io_bit = pick_bit(io_data, fld_bit);
   assign skip_take =
      ((op == csb_pkg::op_skip_reg_bit_clear) & ~reg_bit)
      | ((op == csb_pkg::op_skip_reg_bit_set) & reg_bit)
      | ((op == csb_pkg::op_skip_io_bit_clear) & ~io_bit)
      | ((op == csb_pkg::op_skip_io_bit_set) & io_bit);

   // branch decision
   logic flag_bit;
   logic branch_take;
   logic [csb_pkg::pc_w-1:0] disp;

   assign flag_bit = pick_bit(flags_in, fld_flag);
   assign branch_take =
      ((op == csb_pkg::op_branch_flag_set) & flag_bit)
      | ((op == csb_pkg::op_branch_flag_clear) & ~flag_bit)
      | ((op == csb_pkg::op_branch_named) & named_met(cond, flags_in));
   assign disp = is_bflag ? sext_disp(fld_bdisp) : sext_disp(fld_ndisp);

   // targets and cycle counts
   logic take;
   logic [csb_pkg::pc_w-1:0] target;
   logic [1:0] cycles;
   logic accept;

   assign take = skip_take | branch_take;
   assign target = is_skip
      ? instr_pc + (next_two_word ? csb_pkg::pc_skip_two
         : csb_pkg::pc_skip_one)
      : instr_pc + disp + csb_pkg::pc_rel_base;
   assign cycles = ~take ? csb_pkg::cyc_one
      : (is_branch ? csb_pkg::cyc_branch
         : (next_two_word ? csb_pkg::cyc_skip_two
            : csb_pkg::cyc_skip_one));
   assign accept = instr_valid & instr_ready;
   assign instr_ready = enable_q & (state_q == csb_pkg::st_idle);

   // stall sequencing
   always_comb begin
      state_d = state_q;
      stall_d = stall_q;
      case (state_q)
         csb_pkg::st_idle: begin
            if (accept && cycles != csb_pkg::cyc_one) begin
               state_d = csb_pkg::st_stall;
               stall_d = cycles - csb_pkg::cyc_one;
            end
         end
         csb_pkg::st_stall: begin
            stall_d = stall_q - csb_pkg::cyc_one;
            if (stall_q == csb_pkg::cyc_one) begin
               state_d = csb_pkg::st_idle;
            end
         end
         default: begin
            state_d = csb_pkg::st_idle;
            stall_d = 2'h0;
         end
      endcase
   end

   logic last_cycle;

   assign last_cycle = (accept && cycles == csb_pkg::cyc_one)
      || (state_q == csb_pkg::st_stall && stall_q == csb_pkg::cyc_one);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= csb_pkg::st_idle;
         stall_q <= 2'h0;
         done_q <= 1'h0;
      end else begin
         state_q <= state_d;
         stall_q <= stall_d;
         done_q <= last_cycle;
      end
   end

   // flag write only for compares
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         flags_we_q <= 1'h0;
         flags_out_q <= 8'h00;
      end else begin
         flags_we_q <= accept & is_cmp;
         if (accept && is_cmp) begin
            flags_out_q <= cmp_flags;
         end
      end
   end

   // program counter load
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pc_load_q <= 1'h0;
         pc_target_q <= 16'h0000;
      end else begin
         pc_load_q <= accept & take;
         if (accept && take) begin
            pc_target_q <= target;
         end
      end
   end

   // register port decode
   logic wr_ctrl;
   logic wr_branch_count;
   logic wr_skip_count;
   logic [csb_pkg::bus_data_w-1:0] rd_mux;

   assign wr_ctrl = reg_we && reg_addr == csb_pkg::reg_ctrl;
   assign wr_branch_count = reg_we && reg_addr == csb_pkg::reg_branch_count;
   assign wr_skip_count = reg_we && reg_addr == csb_pkg::reg_skip_count;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (reg_addr)
         csb_pkg::reg_ctrl:
            rd_mux[csb_pkg::ctrl_enable_bit] = enable_q;
         csb_pkg::reg_state: begin
            rd_mux[csb_pkg::state_busy_bit] = (state_q == csb_pkg::st_stall);
            rd_mux[csb_pkg::state_taken_bit] = last_taken_q;
         end
         csb_pkg::reg_branch_count:
            rd_mux[csb_pkg::count_w-1:0] = branch_count_q;
         csb_pkg::reg_skip_count:
            rd_mux[csb_pkg::count_w-1:0] = skip_count_q;
         csb_pkg::reg_last_target:
            rd_mux[csb_pkg::pc_w-1:0] = last_target_q;
         default:
            rd_mux = 32'h0000_0000;
      endcase
   end

   // software registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         enable_q <= csb_pkg::ctrl_enable_rst;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            enable_q <= reg_wdata[csb_pkg::ctrl_enable_bit];
         end
         rdata_q <= reg_re ? rd_mux : 32'h0000_0000;
      end
   end

   // outcome counters, a clear with an event in one cycle leaves a count of one
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         branch_count_q <= 16'h0000;
         skip_count_q <= 16'h0000;
         last_taken_q <= 1'h0;
         last_target_q <= 16'h0000;
      end else begin
         if (accept && branch_take) begin
            branch_count_q <= wr_branch_count ? 16'h0001
               : branch_count_q + 16'h0001;
         end else if (wr_branch_count) begin
            branch_count_q <= 16'h0000;
         end
         if (accept && skip_take) begin
            skip_count_q <= wr_skip_count ? 16'h0001
               : skip_count_q + 16'h0001;
         end else if (wr_skip_count) begin
            skip_count_q <= 16'h0000;
         end
         if (accept && (is_skip || is_branch)) begin
            last_taken_q <= take;
         end
         if (accept && take) begin
            last_target_q <= target;
         end
      end
   end

   // outputs
   assign exec_done = done_q;
   assign flags_we = flags_we_q;
   assign flags_out = flags_out_q;
   assign pc_load = pc_load_q;
   assign pc_target = pc_target_q;
   assign reg_rdata = rdata_q;

endmodule // csb_unit
`default_nettype wire

// >>> sim/csb_unit_chk.sv
// port assertions for the compare, skip and branch unit
`timescale 1ns/1ps
`default_nettype none
module csb_unit_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // instruction side
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [15:0] instr_pc,
   input wire logic next_two_word,
   input wire logic instr_ready,
   input wire logic exec_done,
   // operands and results
   input wire logic [7:0] rf_data_a,
   input wire logic [7:0] io_data,
   input wire logic [7:0] flags_in,
   input wire logic flags_we,
   input wire logic pc_load,
   input wire logic [15:0] pc_target
);
   wire logic take = instr_valid && instr_ready;
   wire logic [3:0] op = instr_word[15:12];
   wire logic [2:0] bs = instr_word[2:0];
   wire logic fl = flags_in[bs];
   wire logic sk = (op == 4'h3 && !rf_data_a[bs]) ||
      (op == 4'h4 && rf_data_a[bs]) || (op == 4'h5 && !io_data[bs]) ||
      (op == 4'h6 && io_data[bs]);
   wire logic [15:0] gt = instr_pc + {{9{instr_word[9]}}, instr_word[9:3]}
      + 16'h0001;
   wire logic [15:0] nt = instr_pc + {{9{instr_word[6]}}, instr_word[6:0]}
      + 16'h0001;
   wire logic [3:0] cd = instr_word[11:8];

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_cmp_flags_once: assert property (take && op < 4'h3 |=>
      flags_we && exec_done && !pc_load) else $error("compare result late");
   a_no_flag_write: assert property (take && op > 4'h2 |=>
      !flags_we) else $error("flags written by skip or branch");
   a_flag_set_branch: assert property (take && op == 4'h7 && fl |=>
      pc_load && pc_target == $past(gt) ##1 exec_done)
      else $error("flag set branch wrong");
   a_flag_clear_branch: assert property (take && op == 4'h8 && !fl |=>
      pc_load && pc_target == $past(gt)) else $error("flag clear branch wrong");
   a_branch_not_taken: assert property (take && ((op == 4'h7 && !fl) ||
      (op == 4'h8 && fl)) |=> exec_done && !pc_load)
      else $error("untaken branch wrong");
   a_skip_short: assert property (take && sk && !next_two_word |=>
      pc_load && pc_target == $past(instr_pc) + 16'h0002 ##1 exec_done)
      else $error("one word skip wrong");
   a_skip_long: assert property (take && sk && next_two_word |=>
      pc_load && pc_target == $past(instr_pc) + 16'h0003 ##1 !exec_done
      ##1 exec_done) else $error("two word skip wrong");
   a_skip_none: assert property (take && op > 4'h2 && op < 4'h7 && !sk |=>
      !pc_load && exec_done) else $error("skip without cause");
   a_equal_branch: assert property (take && op == 4'h9 && cd == 4'h0 &&
      flags_in[1] |=> pc_load && pc_target == $past(nt))
      else $error("equal branch wrong");
   a_signed_ge: assert property (take && op == 4'h9 && cd == 4'h8 &&
      !(flags_in[2] ^ flags_in[3]) |=> pc_load) else $error("ge branch missed");
   a_stall_ready: assert property (pc_load |-> !instr_ready)
      else $error("ready during stall");
endmodule // csb_unit_chk

bind csb_unit csb_unit_chk i_chk (.clk(clk), .rst_b(rst_b),
   .instr_valid(instr_valid), .instr_word(instr_word), .instr_pc(instr_pc),
   .next_two_word(next_two_word), .instr_ready(instr_ready),
   .exec_done(exec_done), .rf_data_a(rf_data_a), .io_data(io_data),
   .flags_in(flags_in), .flags_we(flags_we), .pc_load(pc_load),
   .pc_target(pc_target));
`default_nettype wire

// >>> sim/tb_csb_unit.sv
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
   fails++; end end
module tb_csb_unit;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [15:0] instr_pc = 16'h0100;
   logic next_two_word = 1'b0;
   logic [7:0] rf_data_a = 8'h00;
   logic [7:0] rf_data_b = 8'h00;
   logic [7:0] io_data = 8'h00;
   logic [7:0] flags_in = 8'h00;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic instr_ready, exec_done, flags_we, pc_load, ld, fw;
   logic [4:0] rf_addr_a, rf_addr_b, io_addr;
   logic [7:0] flags_out, fo;
   logic [15:0] pc_target, tgt;
   logic [31:0] reg_rdata;
   int fails = 0;
   int checks_done = 0;
   int n_br = 0;
   int n_sk = 0;
   int cyc;

   always #12.5 clk = ~clk;

   csb_unit i_dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
      .instr_word(instr_word), .instr_pc(instr_pc),
      .next_two_word(next_two_word), .instr_ready(instr_ready),
      .exec_done(exec_done), .rf_addr_a(rf_addr_a), .rf_data_a(rf_data_a),
      .rf_addr_b(rf_addr_b), .rf_data_b(rf_data_b), .io_addr(io_addr),
      .io_data(io_data), .flags_in(flags_in), .flags_we(flags_we),
      .flags_out(flags_out), .pc_load(pc_load), .pc_target(pc_target),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata));

   task automatic give_verdict;
      $display("mismatches %0d, checks %0d", fails, checks_done);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // issue one instruction, gather its outputs until done
   task automatic run(input logic [15:0] w, input logic two,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] f);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      next_two_word <= two;
      rf_data_a <= a;
      io_data <= a;
      rf_data_b <= b;
      flags_in <= f;
      @(posedge clk);
      instr_valid <= 1'b0;
      ld = 1'b0;
      fw = 1'b0;
      cyc = 0;
      for (int i = 1; i < 6 && cyc == 0; i++) begin
         #1;
         if (pc_load === 1'b1) begin
            ld = 1'b1;
            tgt = pc_target;
         end
         if (flags_we === 1'b1) begin
            fw = 1'b1;
            fo = flags_out;
         end
         if (exec_done === 1'b1) cyc = i;
         else @(posedge clk);
      end
      if (cyc == 0) begin
         fails++;
         give_verdict();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 `CHK(reg_rdata, e)
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask

   // expected outcome of a named branch condition
   function automatic logic cond_hit(input logic [3:0] c, input logic [7:0] f);
      logic b;
      case (c[3:1])
         3'h0: b = f[1];
         3'h1: b = f[0];
         3'h2: b = ~f[0];
         3'h3: b = f[2];
         3'h4: b = ~(f[2] ^ f[3]);
         3'h5: b = f[5];
         3'h6: b = f[6];
         default: b = f[3];
      endcase
      return c[0] ? ~b : b;
   endfunction

   task automatic t_compare;
      logic [15:0] w [3] = '{16'h0045, 16'h1045, 16'h2301};
      logic [7:0] a [3] = '{8'h10, 8'h10, 8'h80};
      logic [7:0] b [3] = '{8'h20, 8'h0f, 8'h00};
      logic [7:0] fi [3] = '{8'h50, 8'h01, 8'h00};
      logic [7:0] fx [3] = '{8'h55, 8'h22, 8'h28};
      for (int i = 0; i < 3; i++) begin
         run(w[i], 1'b0, a[i], b[i], fi[i]);
         `CHK(fw, 1'b1)
         `CHK(fo, fx[i])
         `CHK(cyc, 1)
         `CHK(ld, 1'b0)
      end
      `CHK(rf_addr_a, 5'h13)
      `CHK(rf_addr_b, 5'h01)
   endtask

   task automatic t_skip;
      logic [3:0] op;
      logic v, two, hit;
      for (int i = 0; i < 16; i++) begin
         op = 4'h3 + 4'(i[1:0]);
         v = i[2];
         two = i[3];
         hit = op[0] ? ~v : v;
         run(op < 4'h5 ? {op, 3'h0, 5'h07, 1'b0, 3'h5} :
            {op, 4'h0, 5'h07, 3'h5}, two, v ? 8'h20 : 8'hdf, 8'h00, 8'hff);
         `CHK(cyc, hit ? (two ? 3 : 2) : 1)
         `CHK(ld, hit)
         if (hit) `CHK(tgt, 16'h0100 + (two ? 16'h3 : 16'h2))
         `CHK(fw, 1'b0)
         `CHK(op < 4'h5 ? rf_addr_a : io_addr, 5'h07)
         n_sk += int'(hit);
      end
   endtask

   task automatic t_branch;
      logic [6:0] k;
      logic [7:0] m;
      logic hit;
      for (int j = 0; j < 32; j++) begin
         k = j[0] ? 7'h40 : 7'h3f;
         m = 8'h01 << j[2:0];
         hit = (j[4] == 1'b0) == j[3];
         run({j[4] ? 4'h8 : 4'h7, 2'h0, k, 3'(j)}, 1'b0, 8'h00, 8'h00,
            j[3] ? m : ~m);
         `CHK(cyc, hit ? 2 : 1)
         `CHK(ld, hit)
         if (hit) `CHK(tgt, 16'h0101 + {{9{k[6]}}, k})
         `CHK(fw, 1'b0)
         n_br += int'(hit);
      end
   endtask

   task automatic t_named;
      logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h0c, 8'h25};
      logic hit;
      for (int c = 0; c < 64; c++) begin
         hit = cond_hit(4'(c >> 2), pats[c % 4]);
         run({4'h9, 4'(c >> 2), 1'b0, 7'h7e}, 1'b0, 8'h00, 8'h00, pats[c % 4]);
         `CHK(ld, hit)
         `CHK(cyc, hit ? 2 : 1)
         if (hit) `CHK(tgt, 16'h00ff)
         `CHK(fw, 1'b0)
         n_br += int'(hit);
      end
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      #1 `CHK(instr_ready, 1'b1)
      `CHK(pc_load, 1'b0)
      rd(8'h00, 32'h1);
      t_compare();
      t_skip();
      t_branch();
      t_named();
      rd(8'h08, {16'h0, 16'(n_br)});
      rd(8'h0c, {16'h0, 16'(n_sk)});
      rd(8'h04, 32'h2);
      rd(8'h10, 32'h0000_00ff);
      rd(8'h40, 32'h0);
      wr(8'h00, 32'h0);
      #1 `CHK(instr_ready, 1'b0)
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h1);
      rd(8'h08, 32'h0);
      give_verdict();
   end
endmodule // tb_csb_unit
`default_nettype wire
